// File: hw/bsp_event_regs.sv
`timescale 1ns/1ps
// Functional notes
// R1: Set transmit-done flag when last transmit buffer byte has left the line.
// R2: Set receiver-started flag at 0x14C once receiver runs after start task.
// R3: Set transmitter-started flag at 0x150 once transmitter runs after start.
// R4: Receiver-timeout flag at 0x144; enable bit H gates its interrupt.
// R5: Transmitter-stopped flag at 0x158; enable bit L gates its interrupt.
// R6: Any receive error sets error flag at 0x124; enable bit G gates it.
// R7: Shortcut bit C makes receive-buffer-full trigger the receive start task.
// R8: Shortcut bit D makes receive-buffer-full trigger receive stop; else nothing.
// R9: Interrupt enable at 0x300 holds one read-write bit per event.
// R10: Set view 0x304 sets bits written one; read shows enables.
// R11: Clear view 0x308 clears bits written one; read shows enables.
// R12: Start bit while previous byte unread sets overrun bit A.
// R13: With parity checking on, a bad parity bit sets bit B.
// R14: Missing valid stop bit after a character sets framing bit C.
// R15: Line low longer than 10 or 11 bit frame sets break bit D.
// R16: Error bits stay set until software writes one there; zero ignored.
// R17: Block is enabled only while enable field holds 8; 0 disables.
// R18: Software waits for stopped or timeout event before disabling.
// R19: Interrupt output high while any flag and its enable are both one.
// R20: Event flags stay one until software writes zero to them.
module bsp_event_regs
  import bsp_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bsp_evt_s evtIn,
  input wire bsp_rxcond_s rxCond,
  output bsp_task_s taskOut,
  output logic peripheralEnabled,
  output logic irq
);

  logic [EVT_N-1:0] evtFlag;
  logic [EVT_N-1:0] intenReg;
  logic [ERR_N-1:0] errSrc;
  logic [3:0] enableReg;
  logic shortStart;
  logic shortStop;
  logic [3:0] lowCount;
  logic breakSeen;
  logic [DATA_W-1:0] intenView;

  // APB phase decode; writes land on the access cycle that sees pready
  wire setupPhase = psel & ~penable;
  wire wrEn = psel & penable & pwrite & pready;
  wire isShorts = (paddr == OFS_SHORTCUTS);
  wire isInten = (paddr == OFS_INT_ENABLE);
  wire isIntenSet = (paddr == OFS_INT_ENABLE_SET);
  wire isIntenClr = (paddr == OFS_INT_ENABLE_CLEAR);
  wire isErrSrc = (paddr == OFS_RX_ERROR_SOURCE);
  wire isEnable = (paddr == OFS_PERIPH_ENABLE);
  wire [EVT_N-1:0] isEvt;
  wire evtHitAny = |isEvt;
  wire addrHit = evtHitAny | isShorts | isInten | isIntenSet | isIntenClr | isErrSrc | isEnable;
  wire active = (enableReg == ENABLE_ON); // [R17]

  // Error conditions, only counted while the block is enabled
  wire [3:0] frameLen = rxCond.parityCheckOn ? FRAME_BITS_PARITY : FRAME_BITS_PLAIN; // [R15]
  wire breakHit = rxCond.bitTick & ~rxCond.rxLine & ~breakSeen & (lowCount == frameLen); // [R15]
  wire [ERR_N-1:0] errSet;
  assign errSet[ERR_OVERRUN] = active & rxCond.startBitSeen & rxCond.rxHoldFull; // [R12]
  assign errSet[ERR_PARITY] = active & rxCond.parityCheckOn & rxCond.parityBad; // [R13]
  assign errSet[ERR_FRAMING] = active & rxCond.stopBitBad; // [R14]
  assign errSet[ERR_BREAK] = active & breakHit; // [R15]
  wire [ERR_N-1:0] errClr = (wrEn & isErrSrc) ? pwdata[ERR_N-1:0] : '0; // [R16]

  // Event strobes in index order; the error event comes from the error sources
  wire [EVT_N-1:0] evtRaw = {evtIn.transmitterStopped, evtIn.transmitterStarted, evtIn.receiverStarted,
    evtIn.receiverTimeout, |errSet, evtIn.txBufferDone, evtIn.txByteSent, evtIn.rxBufferFull,
    evtIn.rxByteReady, evtIn.clearToSendReleased, evtIn.clearToSend}; // [R6]
  wire [EVT_N-1:0] evtHit = active ? evtRaw : '0;

  // Read multiplexer, reserved bits read zero
  wire [DATA_W-1:0] rdEvt = evtHitAny ? {{(DATA_W-1){1'b0}}, |(isEvt & evtFlag)} : '0;
  wire [DATA_W-1:0] rdShorts = isShorts ? ((DATA_W'(shortStart) << SHORT_START_BIT) |
    (DATA_W'(shortStop) << SHORT_STOP_BIT)) : '0;
  wire [DATA_W-1:0] rdInten = (isInten | isIntenSet | isIntenClr) ? intenView : '0; // [R9] [R10] [R11]
  wire [DATA_W-1:0] rdErr = isErrSrc ? {{(DATA_W-ERR_N){1'b0}}, errSrc} : '0; // [R16]
  wire [DATA_W-1:0] rdEnable = isEnable ? {{(DATA_W-4){1'b0}}, enableReg} : '0;
  wire [DATA_W-1:0] rdMux = rdEvt | rdShorts | rdInten | rdErr | rdEnable;
  wire irqNow = |(evtFlag & intenReg); // [R19]

  // Spread per-event enables onto their documented bit positions
  always_comb begin
    intenView = '0;
    for (int i = 0; i < EVT_N; i++) begin
      intenView[EVT_BIT[i]] = intenReg[i];
    end
  end

  // Per-event flag and enable; a hardware set beats a same-cycle software write
  for (genvar gi = 0; gi < EVT_N; gi++) begin : g_evt
    assign isEvt[gi] = (paddr == EVT_OFS[gi]);
    wire wrFlag = wrEn & isEvt[gi];
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        evtFlag[gi] <= 1'b0;
      end else if (evtHit[gi]) begin
        evtFlag[gi] <= 1'b1; // [R1] [R2] [R3] [R4] [R5] [R6]
      end else if (wrFlag) begin
        evtFlag[gi] <= pwdata[0]; // [R20]
      end
    end
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        intenReg[gi] <= 1'b0;
      end else if (wrEn & isInten) begin
        intenReg[gi] <= pwdata[EVT_BIT[gi]]; // [R9] [R4] [R5] [R6]
      end else if (wrEn & isIntenSet & pwdata[EVT_BIT[gi]]) begin
        intenReg[gi] <= 1'b1; // [R10]
      end else if (wrEn & isIntenClr & pwdata[EVT_BIT[gi]]) begin
        intenReg[gi] <= 1'b0; // [R11]
      end
    end
  end

  // APB answer: ready and data prepared during the setup cycle, zero wait states
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase & ~addrHit;
      if (setupPhase) begin
        prdata <= rdMux;
      end
    end
  end

  // Control registers written by software
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      enableReg <= ENABLE_RESET;
      shortStart <= 1'b0;
      shortStop <= 1'b0;
    end else begin
      if (wrEn & isEnable) begin
        enableReg <= pwdata[3:0]; // [R17]
      end
      if (wrEn & isShorts) begin
        shortStart <= pwdata[SHORT_START_BIT];
        shortStop <= pwdata[SHORT_STOP_BIT];
      end
    end
  end

  // Sticky error sources; a new error wins over a same-cycle clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      errSrc <= '0;
    end else begin
      errSrc <= (errSrc & ~errClr) | errSet; // [R16] [R12] [R13] [R14] [R15]
    end
  end

  // Low-line run length in bit times; one break report per low run
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lowCount <= '0;
      breakSeen <= 1'b0;
    end else if (rxCond.rxLine) begin
      lowCount <= '0;
      breakSeen <= 1'b0;
    end else if (rxCond.bitTick) begin
      if (lowCount != FRAME_BITS_PARITY) begin
        lowCount <= lowCount + 4'h1; // Saturates, enough for either frame length
      end
      if (breakHit) begin
        breakSeen <= 1'b1; // [R15]
      end
    end
  end

  // Registered outputs: interrupt, shortcut tasks, enable status
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq <= 1'b0;
      taskOut <= '0;
      peripheralEnabled <= 1'b0;
    end else begin
      irq <= irqNow; // [R19]
      taskOut.receiveStartTask <= evtHit[IX_RX_FULL] & shortStart; // [R7]
      taskOut.receiveStopTask <= evtHit[IX_RX_FULL] & shortStop; // [R8]
      peripheralEnabled <= active; // [R17]
    end
  end

  // Checker-only low run count, kept apart from the break logic it judges
  logic [4:0] chkLow;
  always_ff @(posedge clock) begin
    if (sys_rst || rxCond.rxLine) begin
      chkLow <= '0;
    end else if (rxCond.bitTick && ~&chkLow) begin
      chkLow <= chkLow + 5'h1;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_irq_raise: assert property (irqNow |=> irq) // [R19]
    else $error("interrupt not raised for enabled pending event");
  a_irq_quiet: assert property (!irqNow |=> !irq) // [R19]
    else $error("interrupt raised with nothing enabled and pending");
  a_short_start: assert property (evtHit[IX_RX_FULL] && shortStart |=> taskOut.receiveStartTask) // [R7]
    else $error("receive start shortcut missed");
  a_short_stop_off: assert property (!(evtHit[IX_RX_FULL] && shortStop) |=> !taskOut.receiveStopTask) // [R8]
    else $error("receive stop task without its shortcut");
  a_txdone_set: assert property (evtHit[IX_TX_DONE] |=> evtFlag[IX_TX_DONE] [*2]) // [R1]
    else $error("transmit done flag not held");
  a_rx_start_flag: assert property (evtIn.receiverStarted && active |=> evtFlag[IX_RX_START]) // [R2]
    else $error("receiver started flag not set");
  a_tx_start_flag: assert property (evtIn.transmitterStarted && active |=> evtFlag[IX_TX_START]) // [R3]
    else $error("transmitter started flag not set");
  a_flag_sticky: assert property (evtFlag[IX_TX_STOP] && !(wrEn && isEvt[IX_TX_STOP]) |=> evtFlag[IX_TX_STOP]) // [R20]
    else $error("event flag dropped without a write");
  a_err_event: assert property (|errSet |=> evtFlag[IX_ERROR]) // [R6]
    else $error("error event not raised by error source");
  a_enable_set: assert property (wrEn && isIntenSet && pwdata[EVT_BIT[IX_RX_TMO]] |=> intenReg[IX_RX_TMO]) // [R10]
    else $error("set view did not enable timeout interrupt");
  a_enable_clr: assert property (wrEn && isIntenClr && pwdata[EVT_BIT[IX_TX_STOP]] |=> !intenReg[IX_TX_STOP]) // [R11]
    else $error("clear view did not disable stopped interrupt");
  a_overrun_set: assert property (active && rxCond.startBitSeen && rxCond.rxHoldFull |=> errSrc[ERR_OVERRUN]) // [R12]
    else $error("overrun not flagged");
  a_error_sticky: assert property (errSrc[ERR_FRAMING] && !(wrEn && isErrSrc) |=> errSrc[ERR_FRAMING]) // [R16]
    else $error("error source dropped without a write");
  a_break_set: assert property (active && breakHit |=> errSrc[ERR_BREAK]) // [R15]
    else $error("break not flagged after a full frame low");
  a_enable_value: assert property (1'b1 |=> peripheralEnabled == $past(enableReg == ENABLE_ON)) // [R17]
    else $error("enable status does not follow the enable field");
  a_apb_answer: assert property (setupPhase |=> pready ##1 !pready)
    else $error("APB answer not exactly one access cycle");

  // Event flags follow their strobes only while enabled
  a_rx_tmo_flag: assert property ( // [R4]
    evtIn.receiverTimeout && active |=> evtFlag[IX_RX_TMO])
    else $error("receiver timeout flag not set");
  a_tx_stop_flag: assert property ( // [R5]
    evtIn.transmitterStopped && active |=> evtFlag[IX_TX_STOP])
    else $error("transmitter stopped flag not set");
  a_tx_done_flag: assert property ( // [R1]
    evtIn.txBufferDone && active |=> evtFlag[IX_TX_DONE])
    else $error("transmit done flag not set");
  a_rx_full_flag: assert property (
    evtIn.rxBufferFull && active |=> evtFlag[IX_RX_FULL])
    else $error("buffer full flag not set");
  a_evt_ignored: assert property ( // [R17]
    !active && !evtFlag[IX_TX_START] && !(wrEn && isEvt[IX_TX_START]) |=> !evtFlag[IX_TX_START])
    else $error("event taken while disabled");
  a_flag_clear: assert property ( // [R20]
    wrEn && isEvt[IX_RX_TMO] && !pwdata[0] && !evtHit[IX_RX_TMO] |=> !evtFlag[IX_RX_TMO])
    else $error("event flag not cleared by zero");
  a_flag_write_one: assert property (
    wrEn && isEvt[IX_TX_DONE] && pwdata[0] |=> evtFlag[IX_TX_DONE])
    else $error("event flag write of one lost");
  a_flag_read: assert property ( // [R2]
    setupPhase && isEvt[IX_RX_START] |=> prdata == DATA_W'($past(evtFlag[IX_RX_START])))
    else $error("event flag read wrong");

  // Interrupt gating and the three enable views
  a_irq_tmo_gate: assert property ( // [R4]
    evtFlag[IX_RX_TMO] && intenReg[IX_RX_TMO] |=> irq)
    else $error("timeout interrupt missing");
  a_irq_stop_gate: assert property ( // [R5]
    evtFlag[IX_TX_STOP] && intenReg[IX_TX_STOP] |=> irq)
    else $error("stopped interrupt missing");
  a_irq_err_gate: assert property ( // [R6]
    evtFlag[IX_ERROR] && intenReg[IX_ERROR] |=> irq)
    else $error("error interrupt missing");
  a_irq_start_gate: assert property ( // [R3]
    evtFlag[IX_TX_START] && intenReg[IX_TX_START] |=> irq)
    else $error("started interrupt missing");
  a_irq_none: assert property ( // [R19]
    !(|evtFlag) |=> !irq)
    else $error("interrupt with no flag pending");
  a_interrupt_enable_write: assert property ( // [R9]
    wrEn && isInten |=> intenReg[IX_TX_STOP] == $past(pwdata[EVT_BIT[IX_TX_STOP]]))
    else $error("enable register write lost");
  a_set_keeps: assert property ( // [R10]
    wrEn && isIntenSet && !pwdata[EVT_BIT[IX_RX_TMO]] |=> $stable(intenReg[IX_RX_TMO]))
    else $error("set view changed a zero bit");
  a_clr_keeps: assert property ( // [R11]
    wrEn && isIntenClr && !pwdata[EVT_BIT[IX_TX_STOP]] |=> $stable(intenReg[IX_TX_STOP]))
    else $error("clear view changed a zero bit");
  a_set_read: assert property ( // [R10]
    setupPhase && isIntenSet |=> prdata == $past(intenView))
    else $error("set view read wrong");
  a_clr_read: assert property ( // [R11]
    setupPhase && isIntenClr |=> prdata == $past(intenView))
    else $error("clear view read wrong");

  // Shortcut tasks and their fields
  a_short_stop: assert property ( // [R8]
    evtHit[IX_RX_FULL] && shortStop |=> taskOut.receiveStopTask)
    else $error("receive stop shortcut missed");
  a_short_start_off: assert property ( // [R7]
    !(evtHit[IX_RX_FULL] && shortStart) |=> !taskOut.receiveStartTask)
    else $error("start task without its shortcut");
  a_short_write: assert property ( // [R8]
    wrEn && isShorts |=> shortStop == $past(pwdata[SHORT_STOP_BIT]))
    else $error("stop shortcut write lost");
  a_short_read: assert property ( // [R7]
    setupPhase && isShorts |=> prdata[SHORT_START_BIT] == $past(shortStart))
    else $error("shortcut read wrong");

  // Error sources: set, hold, clear and break timing
  a_parity_set: assert property ( // [R13]
    active && rxCond.parityCheckOn && rxCond.parityBad |=> errSrc[ERR_PARITY])
    else $error("parity error not flagged");
  a_parity_off: assert property ( // [R13]
    !rxCond.parityCheckOn && !errSrc[ERR_PARITY] |=> !errSrc[ERR_PARITY])
    else $error("parity flagged with checking off");
  a_framing_set: assert property ( // [R14]
    active && rxCond.stopBitBad |=> errSrc[ERR_FRAMING])
    else $error("framing error not flagged");
  a_err_clear: assert property ( // [R16]
    wrEn && isErrSrc && pwdata[ERR_OVERRUN] && !errSet[ERR_OVERRUN] |=> !errSrc[ERR_OVERRUN])
    else $error("overrun not cleared by one");
  a_err_keep_zero: assert property ( // [R16]
    wrEn && isErrSrc && !pwdata[ERR_PARITY] && errSrc[ERR_PARITY] |=> errSrc[ERR_PARITY])
    else $error("parity cleared by zero");
  a_err_gate: assert property ( // [R17]
    !active && !errSrc[ERR_FRAMING] && !(wrEn && isErrSrc) |=> !errSrc[ERR_FRAMING])
    else $error("error taken while disabled");
  a_break_early: assert property ( // [R15]
    $rose(errSrc[ERR_BREAK]) |-> $past(chkLow) >= {1'b0, $past(frameLen)})
    else $error("break flagged before a full frame");
  a_err_read: assert property ( // [R16]
    setupPhase && isErrSrc |=> prdata == DATA_W'($past(errSrc)))
    else $error("error source read wrong");

  // Bus answer and enable field
  a_err_resp: assert property (
    setupPhase && !addrHit |=> pslverr)
    else $error("unmapped access not refused");
  a_no_err: assert property (
    setupPhase && addrHit |=> !pslverr)
    else $error("mapped access refused");
  a_ready_single: assert property (
    pready |=> !pready)
    else $error("ready held two cycles");
  a_unmapped_wr: assert property (
    wrEn && !addrHit |=> $stable(enableReg) && $stable(intenReg))
    else $error("unmapped write changed state");
  a_prdata_hold: assert property (
    !setupPhase |=> $stable(prdata))
    else $error("read data moved outside setup");
  a_enable_gate: assert property ( // [R17]
    !active |=> !taskOut.receiveStartTask && !taskOut.receiveStopTask)
    else $error("task raised while disabled");
  a_enable_read: assert property ( // [R17]
    setupPhase && isEnable |=> prdata == DATA_W'($past(enableReg)))
    else $error("enable field read wrong");

  c_irq_rise: cover property (!irq ##1 irq);
  c_short_start: cover property (taskOut.receiveStartTask);
  c_break: cover property (!errSrc[ERR_BREAK] ##1 errSrc[ERR_BREAK]);
  c_bad_addr: cover property (pready && pslverr);
  c_short_stop: cover property (taskOut.receiveStopTask);

endmodule : bsp_event_regs

// File: hw/bsp_pkg.sv
package bsp_pkg;

  // APB decode width; upper address bits are ignored
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned EVT_N = 11;

  // Event flag register offsets, in event index order
  localparam logic [11:0] OFS_EVT_CTS = 12'h100;
  localparam logic [11:0] OFS_EVT_NOT_CTS = 12'h104;
  localparam logic [11:0] OFS_EVT_RX_BYTE = 12'h108;
  localparam logic [11:0] OFS_EVT_RX_FULL = 12'h110;
  localparam logic [11:0] OFS_EVT_TX_BYTE = 12'h11c;
  localparam logic [11:0] OFS_EVT_TX_DONE = 12'h120;
  localparam logic [11:0] OFS_EVT_ERROR = 12'h124;
  localparam logic [11:0] OFS_EVT_RX_TMO = 12'h144;
  localparam logic [11:0] OFS_EVT_RX_START = 12'h14c;
  localparam logic [11:0] OFS_EVT_TX_START = 12'h150;
  localparam logic [11:0] OFS_EVT_TX_STOP = 12'h158;
  localparam logic [11:0] OFS_SHORTCUTS = 12'h200;
  localparam logic [11:0] OFS_INT_ENABLE = 12'h300;
  localparam logic [11:0] OFS_INT_ENABLE_SET = 12'h304;
  localparam logic [11:0] OFS_INT_ENABLE_CLEAR = 12'h308;
  localparam logic [11:0] OFS_RX_ERROR_SOURCE = 12'h480;
  localparam logic [11:0] OFS_PERIPH_ENABLE = 12'h500;

  localparam logic [11:0] EVT_OFS [EVT_N] = '{OFS_EVT_CTS, OFS_EVT_NOT_CTS, OFS_EVT_RX_BYTE, OFS_EVT_RX_FULL,
    OFS_EVT_TX_BYTE, OFS_EVT_TX_DONE, OFS_EVT_ERROR, OFS_EVT_RX_TMO, OFS_EVT_RX_START, OFS_EVT_TX_START,
    OFS_EVT_TX_STOP};

  // Event indices
  localparam int unsigned IX_RX_FULL = 3;
  localparam int unsigned IX_TX_DONE = 5;
  localparam int unsigned IX_ERROR = 6;
  localparam int unsigned IX_RX_TMO = 7;
  localparam int unsigned IX_RX_START = 8;
  localparam int unsigned IX_TX_START = 9;
  localparam int unsigned IX_TX_STOP = 10;

  // Interrupt enable bit positions A..J, L per event index
  localparam int unsigned EVT_BIT [EVT_N] = '{0, 1, 2, 4, 7, 8, 9, 17, 19, 20, 22};

  // Shortcut field positions
  localparam int unsigned SHORT_START_BIT = 5;
  localparam int unsigned SHORT_STOP_BIT = 6;

  // Error source field positions
  localparam int unsigned ERR_OVERRUN = 0;
  localparam int unsigned ERR_PARITY = 1;
  localparam int unsigned ERR_FRAMING = 2;
  localparam int unsigned ERR_BREAK = 3;
  localparam int unsigned ERR_N = 4;

  localparam logic [3:0] ENABLE_ON = 4'h8;
  localparam logic [3:0] ENABLE_RESET = 4'h0;
  localparam logic [3:0] FRAME_BITS_PLAIN = 4'ha;
  localparam logic [3:0] FRAME_BITS_PARITY = 4'hb;

  // Event strobes from the transceiver core, one cycle each
  typedef struct packed {
    logic transmitterStopped;
    logic transmitterStarted;
    logic receiverStarted;
    logic receiverTimeout;
    logic txBufferDone;
    logic txByteSent;
    logic rxBufferFull;
    logic rxByteReady;
    logic clearToSendReleased;
    logic clearToSend;
  } bsp_evt_s;

  // Receive line conditions feeding the error sources
  typedef struct packed {
    logic startBitSeen;
    logic rxHoldFull;
    logic parityCheckOn;
    logic parityBad;
    logic stopBitBad;
    logic rxLine;
    logic bitTick;
  } bsp_rxcond_s;

  // Task triggers raised by the shortcuts
  typedef struct packed {
    logic receiveStopTask;
    logic receiveStartTask;
  } bsp_task_s;

endpackage : bsp_pkg

// File: verif/bsp_line_model.sv
`timescale 1ns/1ps
module bsp_line_model
  import bsp_pkg::*;
(
  input wire logic clock,
  input wire logic breakGo,
  input wire logic [3:0] lowLen,
  input wire logic [2:0] errReq,
  input wire logic parityOn,
  input wire logic holdFull,
  output bsp_rxcond_s rxCond
);
  logic [1:0] div = 2'h0;
  logic [3:0] lowLeft = 4'h0;
  // Bit time is four clocks, kept short so a whole break run stays cheap
  always @(posedge clock) begin
    div <= div + 2'h1;
    if (breakGo) begin
      lowLeft <= lowLen;
    end else if (rxCond.bitTick && lowLeft != 4'h0) begin
      lowLeft <= lowLeft - 4'h1;
    end
  end
  // Line idles high; held low for exactly lowLen bit ticks
  assign rxCond.bitTick = (div == 2'h3);
  assign rxCond.rxLine = (lowLeft == 4'h0);
  assign rxCond.startBitSeen = errReq[0];
  assign rxCond.parityBad = errReq[1];
  assign rxCond.stopBitBad = errReq[2];
  assign rxCond.parityCheckOn = parityOn;
  assign rxCond.rxHoldFull = holdFull;
endmodule : bsp_line_model

// File: verif/uart_event_irq_error_regs_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module uart_event_irq_error_regs_tb
  import bsp_pkg::*;
;
  logic clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, peripheralEnabled, irq, breakGo = 1'b0, parityOn = 1'b0, holdFull = 1'b0;
  logic [3:0] lowLen = 4'h0;
  logic [2:0] errReq = 3'h0;
  bsp_evt_s evtIn = '0;
  bsp_rxcond_s rxCond;
  bsp_task_s taskOut;
  int n_mismatch = 0, comparisons = 0, startCnt = 0, stopCnt = 0;
  bsp_event_regs u_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evtIn(evtIn),
    .rxCond(rxCond), .taskOut(taskOut), .peripheralEnabled(peripheralEnabled), .irq(irq));
  bsp_line_model u_line (.clock(clock), .breakGo(breakGo), .lowLen(lowLen), .errReq(errReq),
    .parityOn(parityOn), .holdFull(holdFull), .rxCond(rxCond));
  initial forever #2 clock = ~clock;
  // Task pulses are one cycle wide, so count them rather than sample once
  always @(posedge clock) begin
    if (taskOut.receiveStartTask === 1'b1) startCnt++;
    if (taskOut.receiveStopTask === 1'b1) stopCnt++;
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // One APB transfer; a spare edge before setup keeps release and setup apart
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, rdat)
  endtask : rd
  task automatic pulse(input logic [9:0] v);
    @(posedge clock);
    evtIn <= v;
    @(posedge clock);
    evtIn <= '0;
  endtask : pulse
  task automatic perr(input logic [2:0] v);
    @(posedge clock);
    errReq <= v;
    @(posedge clock);
    errReq <= 3'h0;
  endtask : perr
  task automatic brk(input logic [3:0] n, input logic [31:0] e);
    @(posedge clock);
    breakGo <= 1'b1;
    lowLen <= n;
    @(posedge clock);
    breakGo <= 1'b0;
    repeat (64) @(posedge clock);
    rd(OFS_RX_ERROR_SOURCE, e, "break");
  endtask : brk
  task automatic t_reset();
    for (int i = 0; i < EVT_N; i++) rd(EVT_OFS[i], 32'h0, "event reset");
    rd(OFS_SHORTCUTS, 32'h0, "shortcut reset");
    rd(OFS_INT_ENABLE, 32'h0, "enable reset");
    rd(OFS_RX_ERROR_SOURCE, 32'h0, "error reset");
    rd(12'h0fc, 32'h0, "unmapped");
    `CHK("unmapped err", 1'b1, rerr)
    $display("test reset done");
  endtask : t_reset
  task automatic t_enable();
    pulse(10'h100);
    wr(OFS_PERIPH_ENABLE, 32'h9);
    repeat (2) @(posedge clock);
    `CHK("enabled 9", 1'b0, peripheralEnabled)
    wr(OFS_PERIPH_ENABLE, 32'h8);
    repeat (2) @(posedge clock);
    `CHK("enabled 8", 1'b1, peripheralEnabled)
    rd(OFS_EVT_TX_START, 32'h0, "ignored event");
    $display("test enable done");
  endtask : t_enable
  task automatic t_events();
    for (int i = 0; i < EVT_N; i++) if (i != IX_ERROR) begin
      pulse(10'h1 << ((i > IX_ERROR) ? i - 1 : i));
      repeat (3) @(posedge clock);
      rd(EVT_OFS[i], 32'h1, "flag set");
      wr(EVT_OFS[i], 32'h0);
      rd(EVT_OFS[i], 32'h0, "flag clear");
    end
    $display("test events done");
  endtask : t_events
  task automatic t_interrupt_enable();
    wr(OFS_INT_ENABLE, 32'h5);
    wr(OFS_INT_ENABLE_SET, 32'h00420100);
    rd(OFS_INT_ENABLE, 32'h00420105, "enable set");
    wr(OFS_INT_ENABLE_CLEAR, 32'h00020004);
    rd(OFS_INT_ENABLE_SET, 32'h00400101, "set view");
    rd(OFS_INT_ENABLE_CLEAR, 32'h00400101, "clear view");
    pulse(10'h200);
    repeat (3) @(posedge clock);
    `CHK("irq on", 1'b1, irq)
    wr(OFS_INT_ENABLE_CLEAR, 32'h00400000);
    repeat (2) @(posedge clock);
    `CHK("irq masked", 1'b0, irq)
    wr(OFS_INT_ENABLE, 32'h00420000);
    repeat (2) @(posedge clock);
    `CHK("irq again", 1'b1, irq)
    wr(OFS_EVT_TX_STOP, 32'h0);
    repeat (2) @(posedge clock);
    `CHK("irq cleared", 1'b0, irq)
    $display("test interrupt done");
  endtask : t_interrupt_enable
  task automatic t_event_task_shortcuts(input logic [31:0] s);
    int s0 = startCnt, p0 = stopCnt;
    wr(OFS_SHORTCUTS, s);
    pulse(10'h8);
    repeat (3) @(posedge clock);
    `CHK("start task", s[5], startCnt - s0 == 1)
    `CHK("stop task", s[6], stopCnt - p0 == 1)
    wr(OFS_EVT_RX_FULL, 32'h0);
    $display("test shortcut done");
  endtask : t_event_task_shortcuts
  task automatic t_errors();
    perr(3'h1);
    rd(OFS_RX_ERROR_SOURCE, 32'h0, "no overrun");
    holdFull <= 1'b1;
    perr(3'h1);
    holdFull <= 1'b0;
    rd(OFS_RX_ERROR_SOURCE, 32'h1, "overrun");
    rd(OFS_EVT_ERROR, 32'h1, "error event");
    wr(OFS_RX_ERROR_SOURCE, 32'h0);
    rd(OFS_RX_ERROR_SOURCE, 32'h1, "write zero");
    wr(OFS_RX_ERROR_SOURCE, 32'h1);
    rd(OFS_RX_ERROR_SOURCE, 32'h0, "write one");
    perr(3'h2);
    rd(OFS_RX_ERROR_SOURCE, 32'h0, "parity off");
    parityOn <= 1'b1;
    perr(3'h2);
    parityOn <= 1'b0;
    perr(3'h4);
    rd(OFS_RX_ERROR_SOURCE, 32'h6, "parity framing");
    brk(4'ha, 32'h6);
    brk(4'hb, 32'he);
    wr(OFS_RX_ERROR_SOURCE, 32'hf);
    parityOn <= 1'b1;
    brk(4'hb, 32'h0);
    brk(4'hc, 32'h8);
    $display("test errors done");
  endtask : t_errors
  // Stop first, then poll the stopped flag up to eight reads and disable whether or not it was seen
  task automatic t_shutdown();
    int k = 0;
    pulse(10'h200);
    do begin
      apb(1'b0, OFS_EVT_TX_STOP, 32'h0);
      k++;
    end while (rdat !== 32'h1 && k < 8);
    `CHK("stopped seen", 32'h1, rdat)
    wr(OFS_PERIPH_ENABLE, 32'h0);
    repeat (2) @(posedge clock);
    `CHK("enabled 0", 1'b0, peripheralEnabled)
    $display("test shutdown done");
  endtask : t_shutdown
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_enable();
    t_events();
    t_interrupt_enable();
    t_event_task_shortcuts(32'h20);
    t_event_task_shortcuts(32'h40);
    t_event_task_shortcuts(32'h0);
    t_errors();
    t_shutdown();
    wrap_up();
  end
endmodule : uart_event_irq_error_regs_tb
